/* dv/tb_tsoc_timer_control.sv */
// self-checking bench for the timer status, output and trigger control
`timescale 1ns/100ps
`default_nettype none
`include "tsoc_consts.vh"

module tb_tsoc_timer_control;
    logic clock = 1'b0, reset = 1'b1, bus_write = 1'b0, bus_read = 1'b0, trig = 1'b0;
    logic ext_clock_in = 1'b0;
    logic [3:0] bus_addr = 4'h0, req = 4'h0;
    logic [7:0] bus_wdata = 8'h00, bus_rdata, rv;
    logic [2:0] clock_source_sel = 3'h0, irq_en = 3'h0;
    logic match_a, match_b, counter_wrap, counter_cleared, trigger_in_pin;
    logic waveform_out_pin, count_tick, count_halted, timer_irq, event_irq;
    logic [15:0] wt [13] = '{16'h0211, 16'h0011, 16'h0110, 16'h0311, 16'h0C20, 16'h0821,
        16'h0021, 16'h0420, 16'h0931, 16'h0730, 16'h0B31, 16'h0430, 16'h0231};
    // ticks in 64 cycles: select 1 pick 0, select 1 pick 1, select 2 pick 1, select 3 pick 0
    logic [7:0] tk [4] = '{8'h10, 8'h08, 8'h02, 8'h01};
    int error_cnt = 0, comparisons = 0, cyc = 0, n, s;

    always #10 clock = ~clock;

    tsoc_event_src u_src (.clock, .req, .trig_req(trig), .match_a, .match_b, .counter_wrap,
        .counter_cleared, .trigger_in_pin);
    tsoc_timer_control u_dut (.clock, .reset, .bus_addr, .bus_wdata, .bus_write, .bus_read,
        .bus_rdata, .match_a, .match_b, .counter_wrap, .counter_cleared, .clock_source_sel,
        .match_a_irq_enable(irq_en[0]), .match_b_irq_enable(irq_en[1]),
        .wrap_irq_enable(irq_en[2]), .trigger_in_pin, .ext_clock_in, .waveform_out_pin,
        .count_tick, .count_halted, .timer_irq, .event_irq);

    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // bus cycles: each starts and ends on a rising edge
    task wr(input logic [3:0] a, input logic [7:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge clock) bus_write <= 1'b0;
        @(posedge clock);
    endtask

    task chkr(input logic [3:0] a, input logic [7:0] exp, input string what);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge clock) bus_read <= 1'b0;
        @(posedge clock) rv = bus_rdata;
        chk(what, rv, exp);
    endtask

    task ev(input logic [3:0] k);
        req <= k;
        @(posedge clock) req <= 4'h0;
        repeat (3) @(posedge clock);
    endtask

    task flip;
        trig <= !trig;
        repeat (4) @(posedge clock);
    endtask

    task t_reset;
        chk("wave after reset", 8'(waveform_out_pin), 8'h00);
        chkr(`TSOC_ADDR_FLAG_OUT, 8'h10, "flag reg reset");
        chkr(`TSOC_ADDR_TRIG, 8'hE2, "trig reg reset");
        wr(`TSOC_ADDR_TRIG, 8'h1D);
        chkr(`TSOC_ADDR_TRIG, 8'hFF, "trig reg ones");
        wr(`TSOC_ADDR_TRIG, 8'h00);
        wr(`TSOC_ADDR_FLAG_OUT, 8'hEF);
        chkr(`TSOC_ADDR_FLAG_OUT, 8'h1F, "flag reg ones");
        wr(`TSOC_ADDR_FLAG_OUT, 8'h00);
    endtask

    task t_flags;
        for (s = 0; s < 3; s++) begin
            ev(s == 0 ? 4'h2 : s == 1 ? 4'h1 : 4'h4);
            wr(`TSOC_ADDR_FLAG_OUT, 8'h00);
            chkr(`TSOC_ADDR_FLAG_OUT, (8'h80 >> s) | 8'h10, "flag set");
            wr(`TSOC_ADDR_FLAG_OUT, 8'h80 >> s);
            chkr(`TSOC_ADDR_FLAG_OUT, (8'h80 >> s) | 8'h10, "flag kept");
            wr(`TSOC_ADDR_FLAG_OUT, 8'h00);
            chkr(`TSOC_ADDR_FLAG_OUT, 8'h10, "flag cleared");
        end
    endtask

    task t_wave;
        for (s = 0; s < 13; s++) begin
            wr(`TSOC_ADDR_FLAG_OUT, wt[s][15:8]);
            ev(wt[s][7:4]);
            chk("wave pin", 8'(waveform_out_pin), 8'(wt[s][0]));
        end
    endtask

    task t_trig;
        for (s = 1; s < 4; s++) begin
            trig <= (s == 1);
            wr(`TSOC_ADDR_TRIG, 8'(s << 3) | 8'h04);
            ev(4'h8);
            chk("halt on clear", 8'(count_halted), 8'h01);
            if (s != 3) flip;
            chk("wrong edge", 8'(count_halted), 8'h01);
            flip;
            chk("restart", 8'(count_halted), 8'h00);
        end
        wr(`TSOC_ADDR_TRIG, 8'h04);
        ev(4'h8);
        flip;
        flip;
        chk("edges off", 8'(count_halted), 8'h01);
        wr(`TSOC_ADDR_TRIG, 8'h00);
        ev(4'h8);
        chk("no halt", 8'(count_halted), 8'h00);
    endtask

    task t_irq;
        irq_en <= 3'h4;
        repeat (3) @(posedge clock);
        chk("irq wrap only", 8'(timer_irq), 8'h00);
        irq_en <= 3'h1;
        repeat (3) @(posedge clock);
        chk("irq match a", 8'(timer_irq), 8'h01);
        chkr(`TSOC_ADDR_FLAG_OUT, 8'hD2, "flags before clear");
        wr(`TSOC_ADDR_FLAG_OUT, 8'h00);
        @(posedge clock);
        chk("irq cleared", 8'(timer_irq), 8'h00);
        wr(`TSOC_ADDR_EVT_MASK, 8'h01);
        @(posedge clock);
        chk("event irq", 8'(event_irq), 8'h01);
        chkr(`TSOC_ADDR_EVT_STATUS, 8'h0F, "event status");
        chkr(`TSOC_ADDR_EVT_MASK, 8'h01, "event mask");
        wr(`TSOC_ADDR_EVT_STATUS, 8'h01);
        @(posedge clock);
        chk("event irq clear", 8'(event_irq), 8'h00);
        chkr(`TSOC_ADDR_EVT_STATUS, 8'h0E, "event status cleared");
        chkr(4'hF, 8'h00, "unmapped");
        irq_en <= 3'h0;
    endtask

    task t_tick;
        for (s = 0; s < 4; s++) begin
            wr(`TSOC_ADDR_TRIG, 8'(s == 1 || s == 2));
            clock_source_sel <= 3'(s == 0 ? 1 : s);
            repeat (16) @(posedge clock);
            n = 0;
            repeat (64) @(posedge clock) n += count_tick;
            chk("tick count", 8'(n), tk[s]);
        end
        // no ticks while halted after a clear
        wr(`TSOC_ADDR_TRIG, 8'h04);
        clock_source_sel <= 3'h1;
        ev(4'h8);
        n = 0;
        repeat (64) @(posedge clock) n += count_tick;
        chk("ticks while halted", 8'(n), 8'h00);
        wr(`TSOC_ADDR_TRIG, 8'h00);
        clock_source_sel <= 3'h0;
    endtask

    // external clock: rising, falling and both edges
    task t_ext;
        for (s = 5; s < 8; s++) begin
            clock_source_sel <= 3'(s);
            repeat (4) @(posedge clock);
            n = 0;
            repeat (32) begin
                ext_clock_in <= !ext_clock_in;
                @(posedge clock) n += count_tick;
                @(posedge clock) n += count_tick;
            end
            repeat (4) @(posedge clock) n += count_tick;
            chk("ext tick count", 8'(n), s == 7 ? 8'h20 : 8'h10);
        end
        clock_source_sel <= 3'h0;
    endtask

    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            test_done;
        end
    end

    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        t_reset;
        t_flags;
        t_wave;
        t_trig;
        t_irq;
        t_tick;
        t_ext;
        test_done;
    end
endmodule // tb_tsoc_timer_control

`default_nettype wire

/* dv/tsoc_event_src.sv */
// partner model: counter-side event pulses and the trigger pin
`timescale 1ns/100ps
`default_nettype none

module tsoc_event_src (
    input wire logic clock,
    input wire logic [3:0] req,
    input wire logic trig_req,
    output logic match_a,
    output logic match_b,
    output logic counter_wrap,
    output logic counter_cleared,
    output logic trigger_in_pin
);
    // one-cycle event pulses and pin level, a cycle after the request
    always @(posedge clock) begin
        {counter_cleared, counter_wrap, match_b, match_a} <= req;
        trigger_in_pin <= trig_req;
    end
endmodule // tsoc_event_src

`default_nettype wire

/* dv/tsoc_timer_control_monitor.sv */
// port assertions for the timer control block
`timescale 1ns/100ps
`default_nettype none
`include "tsoc_consts.vh"

module tsoc_timer_control_monitor (
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    input wire logic [7:0] bus_rdata,
    input wire logic match_a,
    input wire logic match_b,
    input wire logic counter_cleared,
    input wire logic trigger_in_pin,
    input wire logic match_a_irq_enable,
    input wire logic match_b_irq_enable,
    input wire logic wrap_irq_enable,
    input wire logic waveform_out_pin,
    input wire logic count_halted,
    input wire logic timer_irq
);
    logic [1:0] act_a, act_b, esel;
    logic trg_en, prev_pin;
    // winning action and selected trigger edge
    wire [1:0] win = (match_a && (!match_b || act_a > act_b)) ? act_a : act_b;
    wire hit = (esel[0] & trigger_in_pin & ~prev_pin) | (esel[1] & ~trigger_in_pin & prev_pin);

    function automatic logic wact(input logic [1:0] c, input logic w);
        wact = (c == `TSOC_ACT_KEEP) ? w : (c == `TSOC_ACT_TOGGLE) ? ~w : c[1];
    endfunction

    // shadow of action and trigger fields written over the bus
    always @(posedge clock) begin
        prev_pin <= trigger_in_pin;
        if (reset) begin
            {act_b, act_a} <= 4'h0;
            {esel, trg_en} <= 3'h0;
        end else if (bus_write && bus_addr == `TSOC_ADDR_FLAG_OUT) begin
            {act_b, act_a} <= bus_wdata[3:0];
        end else if (bus_write && bus_addr == `TSOC_ADDR_TRIG) begin
            {esel, trg_en} <= bus_wdata[4:2];
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    wave_start_a: assert property ($fell(reset) |-> !waveform_out_pin)
        else $error("waveform pin not low after reset");
    wave_keep_a: assert property (!match_a && !match_b |=> $stable(waveform_out_pin))
        else $error("waveform pin moved without a match");
    wave_act_a: assert property ((match_a || match_b) |=>
        waveform_out_pin == wact($past(win), $past(waveform_out_pin)))
        else $error("waveform pin wrong after match");
    halt_off_a: assert property (!trg_en |=> !count_halted)
        else $error("halted with trigger start off");
    halt_set_a: assert property (trg_en && counter_cleared && !hit |=> count_halted)
        else $error("no halt after clear");
    halt_resume_a: assert property (count_halted && trg_en && hit |=> !count_halted)
        else $error("selected edge did not restart");
    halt_hold_a: assert property (count_halted && trg_en && !hit |=> count_halted)
        else $error("restart without selected edge");
    rsvd_flag_a: assert property (bus_read && bus_addr == `TSOC_ADDR_FLAG_OUT |=> bus_rdata[4])
        else $error("flag register bit 4 not one");
    rsvd_trig_a: assert property (bus_read && bus_addr == `TSOC_ADDR_TRIG |=>
        (&bus_rdata[7:5]) && bus_rdata[1])
        else $error("trigger register spare bits not one");
    irq_off_a: assert property (
        !(match_a_irq_enable || match_b_irq_enable || wrap_irq_enable) |=> !timer_irq)
        else $error("interrupt with all enables off");

    cover property (match_a && match_b);
    cover property (count_halted ##1 !count_halted);
    cover property (timer_irq);
endmodule // tsoc_timer_control_monitor

bind tsoc_timer_control tsoc_timer_control_monitor u_mon (.clock, .reset, .bus_addr, .bus_wdata,
    .bus_write, .bus_read, .bus_rdata, .match_a, .match_b, .counter_cleared, .trigger_in_pin,
    .match_a_irq_enable, .match_b_irq_enable, .wrap_irq_enable, .waveform_out_pin,
    .count_halted, .timer_irq);

`default_nettype wire

/* logic/tsoc_consts.vh */
// constants for the timer status, output and trigger control block
`ifndef TSOC_CONSTS_VH
`define TSOC_CONSTS_VH

// register addresses on the plain register port
`define TSOC_ADDR_FLAG_OUT 4'h0
`define TSOC_ADDR_TRIG 4'h1
`define TSOC_ADDR_EVT_STATUS 4'h2
`define TSOC_ADDR_EVT_MASK 4'h3

// flag and output control register fields
`define TSOC_BIT_MATCH_B 7
`define TSOC_BIT_MATCH_A 6
`define TSOC_BIT_WRAP 5
`define TSOC_FLAG_RSVD_MASK 8'h10
`define TSOC_FLAG_OUT_RESET 8'h00

// trigger control register fields
`define TSOC_TRIG_EDGE_HI 4
`define TSOC_TRIG_EDGE_LO 3
`define TSOC_TRIG_ENABLE 2
`define TSOC_TRIG_CLOCK_PICK 0
`define TSOC_TRIG_RSVD_MASK 8'hE2
`define TSOC_TRIG_RESET 8'h00

// output action codes
`define TSOC_ACT_KEEP 2'h0
`define TSOC_ACT_LOW 2'h1
`define TSOC_ACT_HIGH 2'h2
`define TSOC_ACT_TOGGLE 2'h3

// edge select codes, shared by trigger pin and external clock
`define TSOC_EDGE_OFF 2'h0
`define TSOC_EDGE_RISE 2'h1
`define TSOC_EDGE_FALL 2'h2
`define TSOC_EDGE_BOTH 2'h3

// event status and mask bits
`define TSOC_EVT_MATCH_A 0
`define TSOC_EVT_MATCH_B 1
`define TSOC_EVT_WRAP 2
`define TSOC_EVT_TRIGGER 3
`define TSOC_EVT_WIDTH 4
`define TSOC_EVT_RESET 4'h0

// prescaler: divider stage width, phi/4 is stage 1, phi/128 is stage 6
`define TSOC_PRESCALE_WIDTH 7
`define TSOC_PRESCALE_RESET 7'h00

// waveform pin level after reset
`define TSOC_WAVE_RESET 1'b0

// read data when nothing is read or the address is unmapped
`define TSOC_RDATA_IDLE 8'h00

`endif

/* logic/tsoc_prescaler.v */
// prescaler and count clock selector for the up counter
`timescale 1ns/100ps
`default_nettype none

module tsoc_prescaler (
    input wire clock,
    input wire reset,
    input wire [2:0] clock_source_sel,
    input wire internal_clock_pick,
    input wire ext_clock_in,
    output reg count_tick
);

`include "tsoc_consts.vh"

reg [`TSOC_PRESCALE_WIDTH-1:0] divider;
reg picked_prev;
reg ext_prev;
reg picked;
reg next_tick;

// free running divider of the system clock
always @(posedge clock) begin
    if (reset) begin
        divider <= `TSOC_PRESCALE_RESET;
    end else begin
        divider <= divider + 7'h01;
    end
end

// pick the divided clock, the pick bit takes the slower of each pair
always @* begin
    picked = 1'b0;
    case (clock_source_sel)
        3'h1: picked = internal_clock_pick ? divider[2] : divider[1];
        3'h2: picked = internal_clock_pick ? divider[4] : divider[3];
        3'h3: picked = internal_clock_pick ? divider[6] : divider[5];
        default: picked = 1'b0;
    endcase
end

// falling edge of internal clock, or selected edge of external clock
always @* begin
    next_tick = 1'b0;
    if (!clock_source_sel[2]) begin
        next_tick = picked_prev & ~picked;
    end else begin
        case (clock_source_sel[1:0])
            `TSOC_EDGE_RISE: next_tick = ext_clock_in & ~ext_prev;
            `TSOC_EDGE_FALL: next_tick = ~ext_clock_in & ext_prev;
            `TSOC_EDGE_BOTH: next_tick = ext_clock_in ^ ext_prev;
            default: next_tick = 1'b0;
        endcase
    end
end

// edge history and registered tick
always @(posedge clock) begin
    if (reset) begin
        picked_prev <= 1'b0;
        ext_prev <= 1'b0;
        count_tick <= 1'b0;
    end else begin
        picked_prev <= picked;
        ext_prev <= ext_clock_in;
        count_tick <= next_tick;
    end
end

endmodule // tsoc_prescaler

`default_nettype wire

/* logic/tsoc_timer_control.v */
// status flags, waveform output and trigger start control of the 8-bit timer
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module tsoc_timer_control (
    input wire clock,
    input wire reset,
    input wire [3:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_write,
    input wire bus_read,
    output reg [7:0] bus_rdata,
    input wire match_a,
    input wire match_b,
    input wire counter_wrap,
    input wire counter_cleared,
    input wire [2:0] clock_source_sel,
    input wire match_a_irq_enable,
    input wire match_b_irq_enable,
    input wire wrap_irq_enable,
    input wire trigger_in_pin,
    input wire ext_clock_in,
    output reg waveform_out_pin,
    output reg count_tick,
    output reg count_halted,
    output reg timer_irq,
    output reg event_irq
);

`include "tsoc_consts.vh"

// flag and output control register state
reg match_b_flag;
reg match_a_flag;
reg wrap_flag;
reg [1:0] match_b_action;
reg [1:0] match_a_action;
// flags seen as 1 by a read, ready to be cleared by a 0 write
reg match_b_armed;
reg match_a_armed;
reg wrap_armed;

// trigger control register state
reg [1:0] trigger_edge_sel;
reg trigger_start_enable;
reg internal_clock_pick;

// event status and mask
reg [`TSOC_EVT_WIDTH-1:0] event_status;
reg [`TSOC_EVT_WIDTH-1:0] event_mask;

// trigger pin history and the divided count tick
reg trigger_prev;
wire prescale_tick;

// next values from the combinational processes
reg next_match_b_flag;
reg next_match_a_flag;
reg next_wrap_flag;
reg next_waveform;
reg next_halted;
reg trigger_hit;
reg [`TSOC_EVT_WIDTH-1:0] next_event_status;
reg [7:0] next_rdata;

// register port strobes decoded by address
wire write_flag_out = bus_write && (bus_addr == `TSOC_ADDR_FLAG_OUT);
wire read_flag_out = bus_read && (bus_addr == `TSOC_ADDR_FLAG_OUT);
wire write_trig = bus_write && (bus_addr == `TSOC_ADDR_TRIG);
wire write_evt_status = bus_write && (bus_addr == `TSOC_ADDR_EVT_STATUS);
wire write_evt_mask = bus_write && (bus_addr == `TSOC_ADDR_EVT_MASK);

// combine both match actions into one pin decision
function [1:0] merge_action;
    input hit_a;
    input [1:0] act_a;
    input hit_b;
    input [1:0] act_b;
    reg [1:0] a;
    reg [1:0] b;
    begin
        a = hit_a ? act_a : `TSOC_ACT_KEEP;
        b = hit_b ? act_b : `TSOC_ACT_KEEP;
        // toggle beats high, high beats low, low beats keep
        if (a == `TSOC_ACT_TOGGLE || b == `TSOC_ACT_TOGGLE) begin
            merge_action = `TSOC_ACT_TOGGLE;
        end else if (a == `TSOC_ACT_HIGH || b == `TSOC_ACT_HIGH) begin
            merge_action = `TSOC_ACT_HIGH;
        end else if (a == `TSOC_ACT_LOW || b == `TSOC_ACT_LOW) begin
            merge_action = `TSOC_ACT_LOW;
        end else begin
            merge_action = `TSOC_ACT_KEEP;
        end
    end
endfunction

// next flag value: set wins, clear needs an armed flag and a 0 write
function next_flag;
    input flag;
    input set;
    input armed;
    input wbit;
    input wr;
    begin
        // a new event beats a clear in the same cycle
        if (set) begin
            next_flag = 1'b1;
        end else if (wr && armed && !wbit) begin
            next_flag = 1'b0;
        end else begin
            next_flag = flag;
        end
    end
endfunction

// count clock selection and prescaling
tsoc_prescaler u_prescaler (
    .clock(clock),
    .reset(reset),
    .clock_source_sel(clock_source_sel),
    .internal_clock_pick(internal_clock_pick),
    .ext_clock_in(ext_clock_in),
    .count_tick(prescale_tick)
);

// status flag next values
always @* begin
    next_match_b_flag = next_flag(match_b_flag, match_b, match_b_armed,
        bus_wdata[`TSOC_BIT_MATCH_B], write_flag_out);
    next_match_a_flag = next_flag(match_a_flag, match_a, match_a_armed,
        bus_wdata[`TSOC_BIT_MATCH_A], write_flag_out);
    next_wrap_flag = next_flag(wrap_flag, counter_wrap, wrap_armed,
        bus_wdata[`TSOC_BIT_WRAP], write_flag_out);
end

// waveform pin from the merged match action
always @* begin
    case (merge_action(match_a, match_a_action, match_b, match_b_action))
        `TSOC_ACT_LOW: next_waveform = 1'b0;
        `TSOC_ACT_HIGH: next_waveform = 1'b1;
        `TSOC_ACT_TOGGLE: next_waveform = ~waveform_out_pin;
        default: next_waveform = waveform_out_pin;
    endcase
end

// trigger edge detection and halt state
always @* begin
    case (trigger_edge_sel)
        `TSOC_EDGE_RISE: trigger_hit = trigger_in_pin & ~trigger_prev;
        `TSOC_EDGE_FALL: trigger_hit = ~trigger_in_pin & trigger_prev;
        `TSOC_EDGE_BOTH: trigger_hit = trigger_in_pin ^ trigger_prev;
        default: trigger_hit = 1'b0;
    endcase
    // an edge beats a clear in the same cycle
    if (!trigger_start_enable) begin
        next_halted = 1'b0;
    end else if (trigger_hit) begin
        next_halted = 1'b0;
    end else if (counter_cleared) begin
        next_halted = 1'b1;
    end else begin
        next_halted = count_halted;
    end
end

// event status: events set, writing one clears, set wins
always @* begin
    next_event_status = event_status;
    if (write_evt_status) begin
        next_event_status = event_status & ~bus_wdata[`TSOC_EVT_WIDTH-1:0];
    end
    next_event_status[`TSOC_EVT_MATCH_A] = next_event_status[`TSOC_EVT_MATCH_A] | match_a;
    next_event_status[`TSOC_EVT_MATCH_B] = next_event_status[`TSOC_EVT_MATCH_B] | match_b;
    next_event_status[`TSOC_EVT_WRAP] = next_event_status[`TSOC_EVT_WRAP] | counter_wrap;
    // restart event only when a selected edge ends a halt
    next_event_status[`TSOC_EVT_TRIGGER] = next_event_status[`TSOC_EVT_TRIGGER]
        | (trigger_start_enable & trigger_hit & count_halted);
end

// read data decode
always @* begin
    next_rdata = `TSOC_RDATA_IDLE;
    if (bus_read) begin
        if (bus_addr == `TSOC_ADDR_FLAG_OUT) begin
            // spare bit 4 forced to one
            next_rdata = {match_b_flag, match_a_flag, wrap_flag, 1'b0,
                match_b_action, match_a_action} | `TSOC_FLAG_RSVD_MASK;
        end else if (bus_addr == `TSOC_ADDR_TRIG) begin
            next_rdata = {3'h0, trigger_edge_sel, trigger_start_enable, 1'b0,
                internal_clock_pick} | `TSOC_TRIG_RSVD_MASK;
        end else if (bus_addr == `TSOC_ADDR_EVT_STATUS) begin
            next_rdata = {4'h0, event_status};
        end else if (bus_addr == `TSOC_ADDR_EVT_MASK) begin
            next_rdata = {4'h0, event_mask};
        end else begin
            next_rdata = `TSOC_RDATA_IDLE;
        end
    end
end

// flag and output control register
always @(posedge clock) begin
    if (reset) begin
        match_b_flag <= 1'b0;
        match_a_flag <= 1'b0;
        wrap_flag <= 1'b0;
        match_b_action <= `TSOC_ACT_KEEP;
        match_a_action <= `TSOC_ACT_KEEP;
        match_b_armed <= 1'b0;
        match_a_armed <= 1'b0;
        wrap_armed <= 1'b0;
    end else begin
        match_b_flag <= next_match_b_flag;
        match_a_flag <= next_match_a_flag;
        wrap_flag <= next_wrap_flag;
        // any write disarms, a read arms the flags it saw set
        if (write_flag_out) begin
            match_b_action <= bus_wdata[3:2];
            match_a_action <= bus_wdata[1:0];
            match_b_armed <= 1'b0;
            match_a_armed <= 1'b0;
            wrap_armed <= 1'b0;
        end else if (read_flag_out) begin
            match_b_armed <= match_b_armed | match_b_flag;
            match_a_armed <= match_a_armed | match_a_flag;
            wrap_armed <= wrap_armed | wrap_flag;
        end
    end
end

// trigger control register, reserved bits are not stored
always @(posedge clock) begin
    if (reset) begin
        trigger_edge_sel <= `TSOC_EDGE_OFF;
        trigger_start_enable <= 1'b0;
        internal_clock_pick <= 1'b0;
    end else if (write_trig) begin
        // spare bits of the written byte are dropped
        trigger_edge_sel <= bus_wdata[`TSOC_TRIG_EDGE_HI:`TSOC_TRIG_EDGE_LO];
        trigger_start_enable <= bus_wdata[`TSOC_TRIG_ENABLE];
        internal_clock_pick <= bus_wdata[`TSOC_TRIG_CLOCK_PICK];
    end
end

// event status and mask
always @(posedge clock) begin
    if (reset) begin
        event_status <= `TSOC_EVT_RESET;
        event_mask <= `TSOC_EVT_RESET;
    end else begin
        // status follows its next value, mask changes only on a write
        event_status <= next_event_status;
        if (write_evt_mask) begin
            event_mask <= bus_wdata[`TSOC_EVT_WIDTH-1:0];
        end
    end
end

// pin, halt, tick, interrupt and read data outputs
always @(posedge clock) begin
    if (reset) begin
        waveform_out_pin <= `TSOC_WAVE_RESET;
        trigger_prev <= 1'b0;
        count_halted <= 1'b0;
        count_tick <= 1'b0;
        timer_irq <= 1'b0;
        event_irq <= 1'b0;
        bus_rdata <= `TSOC_RDATA_IDLE;
    end else begin
        waveform_out_pin <= next_waveform;
        trigger_prev <= trigger_in_pin;
        count_halted <= next_halted;
        count_tick <= prescale_tick & ~next_halted; // gated while halted
        // interrupts follow the values being stored
        timer_irq <= (next_match_a_flag & match_a_irq_enable)
            | (next_match_b_flag & match_b_irq_enable)
            | (next_wrap_flag & wrap_irq_enable);
        event_irq <= |(next_event_status & event_mask);
        // read data stands one cycle, then idle
        bus_rdata <= next_rdata;
    end
end

endmodule // tsoc_timer_control

`default_nettype wire
